//--- cfg_access_pkg.sv
// constants and types shared by the switch configuration access port
// Summary of operation
// [R01] latch strap levels at reset as defaults
// [R02] flow strap 1 forces flow control everywhere
// [R03] width strap: 0 is 16-bit, 1 32-bit
// [R04] port 5 strap picks MII, GPSI, RMII
// [R05] back-pressure strap enables half-duplex back-pressure
// [R06] autoneg strap enables twisted-pair ports only
// [R07] crossover strap enables twisted-pair ports only
// [R08] led strap: single or dual colour
// [R09] load rom only after matching signature word
// [R10] rom data-out held low skips loading
// [R11] host keeps pins floating during load
// [R12] rom-format write updates addressed register
// [R13] rom-format read gets no device answer
// [R14] host adds one clock between commands
// [R15] management clock no faster than 25 MHz; code samples it with the 10 MHz system clock, so below 5 MHz only
// [R16] host sends 32-bit preamble once first
// [R17] frame: start 01, opcode read/write
// [R18] 10-bit address follows, msb first
// [R19] read turnaround then 16 data bits
// [R20] no preamble later, one idle bit
// [R21] foreign address keeps data pin floating
// [R22] pin directions per operating phase
// [R23] data field msb first, rising edge
package cfg_access_pkg;
	// eeprom clock timing
	localparam int         SYS_CLK_KHZ      = 10_000;
	localparam int         LOAD_SK_HALF_NS  = 400;
	localparam int         LOAD_SK_HALF_CYC = (LOAD_SK_HALF_NS * SYS_CLK_KHZ + 999_999) / 1_000_000;
	localparam logic [2:0] LOAD_DIV_LAST    = 3'(LOAD_SK_HALF_CYC - 1);
	// eeprom load sequence, counted in serial clock edges
	localparam logic [4:0] EE_CMD_BITS      = 5'h0b;
	localparam logic [4:0] LOAD_FIRST_DATA  = 5'h0c;
	localparam logic [4:0] LOAD_LAST_DATA   = 5'h1b;
	localparam logic [4:0] LOAD_GAP         = 5'h1c;
	localparam logic [7:0] LOAD_LAST_WORD   = 8'h9c;
	localparam logic [1:0] EE_OP_READ       = 2'h2;
	localparam logic [1:0] EE_OP_WRITE      = 2'h1;
	// management frame field counts and codes
	localparam logic [5:0] PREAMBLE_LAST    = 6'h1f;
	localparam logic [5:0] OP_CNT_LAST      = 6'h01;
	localparam logic [5:0] ADDR_CNT_LAST    = 6'h09;
	localparam logic [5:0] TA_CNT_LAST      = 6'h01;
	localparam logic [5:0] DATA_CNT_LAST    = 6'h0f;
	localparam logic [5:0] EE_ADDR_CNT_LAST = 6'h07;
	localparam logic [1:0] MGMT_OP_READ     = 2'h2;
	localparam logic [1:0] MGMT_OP_WRITE    = 2'h1;
	localparam logic [9:0] MGMT_ADDR_LAST   = 10'h02ff;
	// strap encodings
	localparam logic [1:0] P5_MII           = 2'h0;
	localparam logic [1:0] P5_RESERVED      = 2'h3;
	localparam logic [5:0] ALL_PORTS        = 6'h3f;
	// top level phases
	typedef enum logic [3:0] {
		ST_CAPTURE = 4'b0001,
		ST_PROBE   = 4'b0010,
		ST_LOAD    = 4'b0100,
		ST_SERVE   = 4'b1000
	} top_state_t;
	// serial frame decoder states
	typedef enum logic [12:0] {
		F_PRE   = 13'b0_0000_0000_0001,
		F_IDLE  = 13'b0_0000_0000_0010,
		F_ST    = 13'b0_0000_0000_0100,
		F_OP    = 13'b0_0000_0000_1000,
		F_ADDR  = 13'b0_0000_0001_0000,
		F_TA    = 13'b0_0000_0010_0000,
		F_DATA  = 13'b0_0000_0100_0000,
		F_REL   = 13'b0_0000_1000_0000,
		F_EST   = 13'b0_0001_0000_0000,
		F_EOP   = 13'b0_0010_0000_0000,
		F_EADDR = 13'b0_0100_0000_0000,
		F_EDATA = 13'b0_1000_0000_0000,
		F_EWAIT = 13'b1_0000_0000_0000
	} frame_state_t;
endpackage : cfg_access_pkg

//--- cfg_sync2.sv
// two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module cfg_sync2 #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk,
	// asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	// first and second stage; only the second stage is read outside
	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} sync_t;
	sync_t st_q;
	sync_t st_d;
	// next stage values
	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end
	// data path only, no reset needed
	always_ff @(posedge clk) begin
		st_q <= st_d;
	end
	assign q = st_q.s2;
endmodule : cfg_sync2
`default_nettype wire

//--- switch_config_access_port.sv
// strap latch, eeprom auto-load and shared serial management port of the switch
`timescale 1ns/1ps
`default_nettype none
module switch_config_access_port
	import cfg_access_pkg::*;
#(
	parameter logic [15:0] SIGNATURE_WORD = 16'h5a3c // arbitrary value
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// configuration straps
	input  wire logic        global_flow_ctrl_strap,
	input  wire logic        mgmt_width_strap,
	input  wire logic [1:0]  port5_bus_strap,
	input  wire logic        backpressure_strap,
	input  wire logic        autoneg_strap,
	input  wire logic        crossover_strap,
	input  wire logic        led_style_strap,
	// per-port board facts and loaded settings
	input  wire logic [5:0]  port_is_fiber,
	input  wire logic [5:0]  port_flow_cfg,
	// shared serial pins
	input  wire logic        rom_select_pin_i,
	output logic             rom_select_pin_o,
	output logic             rom_select_pin_oe,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe,
	input  wire logic        serial_data_pin_i,
	output logic             serial_data_pin_o,
	output logic             serial_data_pin_oe,
	input  wire logic        rom_data_out_pin_i,
	// internal register file access
	output logic             reg_wr_stb,
	output logic             reg_rd_stb,
	output logic [9:0]       reg_addr,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata,
	// effective settings
	output logic [5:0]       flow_ctrl_en,
	output logic             mgmt_wide_mode,
	output logic [1:0]       port5_mode,
	output logic             backpressure_en,
	output logic [5:0]       autoneg_en,
	output logic [5:0]       crossover_en,
	output logic             led_dual_color,
	// status
	output logic             load_busy,
	output logic             load_done,
	output logic             signature_ok
);
	// complete state of the block
	typedef struct packed {
		top_state_t   top;      // operating phase
		frame_state_t fr;       // serial frame decoder
		logic         gfc;      // captured straps
		logic         wide;
		logic [1:0]   p5;
		logic         bp;
		logic         an;
		logic         xo;
		logic         led;
		logic [5:0]   fc;       // per-port flow control
		logic [5:0]   an_en;    // per-port autoneg
		logic [5:0]   xo_en;    // per-port crossover
		logic [2:0]   div;      // eeprom clock divider
		logic [4:0]   bit_n;    // rising edges in current word
		logic [7:0]   word;     // eeprom word being read
		logic         cs_o;     // pin drive values
		logic         sk_o;
		logic         sd_o;
		logic         pins_oe;  // select and clock driven
		logic         sd_oe;    // data pin driven
		logic [15:0]  sh;       // shared shift register
		logic [5:0]   cnt;      // field bit counter
		logic         pre_ok;   // initial preamble seen
		logic         is_rd;    // frame is a read
		logic         match;    // address is ours
		logic [9:0]   addr;     // frame address
		logic         sk_prev;  // last synchronised clock level
		logic         cs_prev;  // last synchronised select level
		logic         wr;       // register strobes and bus
		logic         rd;
		logic [9:0]   ra;
		logic [15:0]  wd;
		logic         busy;     // status
		logic         done;
		logic         sig_ok;
	} state_t;
	localparam state_t RESET_STATE = '{top: ST_CAPTURE, fr: F_PRE, default: '0};
	state_t st_q;
	state_t st_d;
	// synchronised pins and straps
	logic cs_s;
	logic sk_s;
	logic sd_s;
	logic eo_s;
	logic gfc_s;
	logic wide_s;
	logic [1:0] p5_s;
	logic bp_s;
	logic an_s;
	logic xo_s;
	logic led_s;
	// all pins and straps pass two flip-flops before use
	cfg_sync2 #(
		.W (12)
	) u_sync (
		.clk (sys_clk),
		.d   ({rom_select_pin_i, serial_clock_pin_i, serial_data_pin_i, rom_data_out_pin_i,
		       global_flow_ctrl_strap, mgmt_width_strap, port5_bus_strap, backpressure_strap,
		       autoneg_strap, crossover_strap, led_style_strap}),
		.q   ({cs_s, sk_s, sd_s, eo_s, gfc_s, wide_s, p5_s, bp_s, an_s, xo_s, led_s})
	);
	// edges of the sampled management clock
	logic rise;
	logic fall;
	assign rise = sk_s & ~st_q.sk_prev; // R15
	assign fall = ~sk_s & st_q.sk_prev;
	// next state
	always_comb begin
		logic [15:0] nsh;
		logic [9:0]  na;
		nsh = {st_q.sh[14:0], eo_s};
		na  = {st_q.sh[8:0], sd_s};
		st_d = st_q;
		st_d.wr = 1'b0;
		st_d.rd = 1'b0;
		st_d.sk_prev = sk_s;
		st_d.cs_prev = cs_s;
		// effective per-port settings follow captured straps
		st_d.fc    = st_q.gfc ? ALL_PORTS : port_flow_cfg; // R02
		st_d.an_en = {6{st_q.an}} & ~port_is_fiber; // R06
		st_d.xo_en = {6{st_q.xo}} & ~port_is_fiber; // R07
		unique case (st_q.top)
			// first cycle after reset: latch straps, all pins stay inputs
			ST_CAPTURE: begin
				st_d.gfc  = gfc_s; // R01
				st_d.wide = wide_s; // R03
				st_d.p5   = (p5_s == P5_RESERVED) ? P5_MII : p5_s; // R04
				st_d.bp   = bp_s; // R05
				st_d.an   = an_s;
				st_d.xo   = xo_s;
				st_d.led  = led_s; // R08
				st_d.busy = 1'b1;
				st_d.top  = ST_PROBE;
			end
			// rom data-out pulled low means no auto-load
			ST_PROBE: begin
				if (!eo_s) begin
					st_d.top  = ST_SERVE; // R10
					st_d.busy = 1'b0;
					st_d.done = 1'b1;
				end else begin
					st_d.top     = ST_LOAD;
					st_d.cs_o    = 1'b1;
					st_d.sk_o    = 1'b0;
					st_d.sd_o    = 1'b1;
					st_d.pins_oe = 1'b1; // R22
					st_d.sd_oe   = 1'b1;
					st_d.div     = '0;
					st_d.bit_n   = '0;
					st_d.word    = '0;
					st_d.sh      = {1'b1, EE_OP_READ, 8'h00, 5'h00};
				end
			end
			// read words from the eeprom, one read command per word
			ST_LOAD: begin
				if (st_q.div == LOAD_DIV_LAST) begin
					st_d.div  = '0;
					st_d.sk_o = ~st_q.sk_o;
					if (!st_q.sk_o) begin
						// rising edge: eeprom takes command bit or shifts data out
						st_d.bit_n = st_q.bit_n + 5'h01;
					end else if (st_q.bit_n == LOAD_GAP) begin
						// one spare clock with select low, then next command
						st_d.cs_o  = 1'b1;
						st_d.bit_n = '0;
						st_d.sd_o  = 1'b1;
						st_d.sh    = {1'b1, EE_OP_READ, st_q.word, 5'h00};
					end else begin
						// falling edge: shift command out and data in
						st_d.sh   = nsh;
						st_d.sd_o = (st_q.bit_n < EE_CMD_BITS) ? nsh[15] : 1'b0;
						if (st_q.bit_n == LOAD_LAST_DATA) begin
							st_d.cs_o = 1'b0;
							if (st_q.word == 8'h00 && nsh != SIGNATURE_WORD) begin
								// no valid signature: stop loading
								st_d.top     = ST_SERVE; // R09
								st_d.pins_oe = 1'b0;
								st_d.sd_oe   = 1'b0;
								st_d.busy    = 1'b0;
								st_d.done    = 1'b1;
							end else begin
								st_d.wr   = 1'b1;
								st_d.ra   = {2'b00, st_q.word};
								st_d.wd   = nsh;
								st_d.word = st_q.word + 8'h01;
								if (st_q.word == 8'h00) begin
									st_d.sig_ok = 1'b1; // R09
								end
								if (st_q.word == LOAD_LAST_WORD) begin
									st_d.top     = ST_SERVE;
									st_d.pins_oe = 1'b0;
									st_d.sd_oe   = 1'b0;
									st_d.busy    = 1'b0;
									st_d.done    = 1'b1;
								end
							end
						end
					end
				end else begin
					st_d.div = st_q.div + 3'h1;
				end
			end
			// host access over the shared pins
			ST_SERVE: begin
				st_d.pins_oe = 1'b0; // R22
				if (cs_s && !st_q.cs_prev) begin
					// select raised: rom-format command begins
					st_d.fr    = F_EST;
					st_d.sd_oe = 1'b0;
				end else if (!cs_s && (st_q.fr inside {F_EST, F_EOP, F_EADDR, F_EDATA, F_EWAIT})) begin
					st_d.fr = st_q.pre_ok ? F_IDLE : F_PRE;
				end else if (rise) begin
					st_d.cnt = st_q.cnt + 6'h01;
					unique case (st_q.fr)
						// count the one-time preamble of ones
						F_PRE: begin
							if (!sd_s) begin
								st_d.cnt = '0;
							end else if (st_q.cnt == PREAMBLE_LAST) begin
								st_d.pre_ok = 1'b1;
								st_d.fr     = F_IDLE;
							end
						end
						// idle ones until the start pattern's zero
						F_IDLE: begin
							if (!sd_s) begin
								st_d.fr = F_ST; // R20
							end
						end
						F_ST: begin
							if (sd_s) begin
								st_d.fr  = F_OP; // R17
								st_d.cnt = '0;
							end
						end
						// opcode: read or write, anything else dropped
						F_OP: begin
							st_d.sh = {st_q.sh[14:0], sd_s};
							if (st_q.cnt == OP_CNT_LAST) begin
								st_d.cnt   = '0;
								st_d.is_rd = ({st_q.sh[0], sd_s} == MGMT_OP_READ);
								if ({st_q.sh[0], sd_s} == MGMT_OP_READ ||
								    {st_q.sh[0], sd_s} == MGMT_OP_WRITE) begin
									st_d.fr = F_ADDR; // R17
								end else begin
									st_d.fr = F_IDLE;
								end
							end
						end
						// ten address bits, msb first
						F_ADDR: begin
							st_d.sh = {st_q.sh[14:0], sd_s};
							if (st_q.cnt == ADDR_CNT_LAST) begin
								st_d.addr  = na; // R18
								st_d.match = (na <= MGMT_ADDR_LAST); // R21
								st_d.ra    = na;
								st_d.rd    = st_q.is_rd && (na <= MGMT_ADDR_LAST);
								st_d.fr    = F_TA;
								st_d.cnt   = '0;
							end
						end
						// two turnaround bits, read data fetched at the end
						F_TA: begin
							if (st_q.cnt == TA_CNT_LAST) begin
								st_d.fr  = F_DATA; // R19
								st_d.cnt = '0;
								st_d.sh  = reg_rdata;
							end
						end
						// sixteen data bits, msb first
						F_DATA: begin
							if (!st_q.is_rd) begin
								st_d.sh = {st_q.sh[14:0], sd_s}; // R23
							end
							if (st_q.cnt == DATA_CNT_LAST) begin
								st_d.fr = st_q.is_rd ? F_REL : F_IDLE;
								if (!st_q.is_rd && st_q.match) begin
									st_d.wr = 1'b1;
									st_d.ra = st_q.addr;
									st_d.wd = {st_q.sh[14:0], sd_s};
								end
							end
						end
						// wait for the falling edge that releases the pin
						F_REL: begin
						end
						// rom-format start bit
						F_EST: begin
							if (sd_s) begin
								st_d.fr  = F_EOP;
								st_d.cnt = '0;
							end
						end
						// only writes reach the registers; reads are left to the rom
						F_EOP: begin
							st_d.sh = {st_q.sh[14:0], sd_s};
							if (st_q.cnt == OP_CNT_LAST) begin
								st_d.cnt = '0;
								st_d.fr  = ({st_q.sh[0], sd_s} == EE_OP_WRITE) ? F_EADDR : F_EWAIT; // R13
							end
						end
						F_EADDR: begin
							st_d.sh = {st_q.sh[14:0], sd_s};
							if (st_q.cnt == EE_ADDR_CNT_LAST) begin
								st_d.addr = {2'b00, st_q.sh[6:0], sd_s};
								st_d.cnt  = '0;
								st_d.fr   = F_EDATA;
							end
						end
						F_EDATA: begin
							st_d.sh = {st_q.sh[14:0], sd_s};
							if (st_q.cnt == DATA_CNT_LAST) begin
								st_d.wr = 1'b1; // R12
								st_d.ra = st_q.addr;
								st_d.wd = {st_q.sh[14:0], sd_s};
								st_d.fr = F_EWAIT;
							end
						end
						// rest of the command until select drops
						F_EWAIT: begin
						end
					endcase
				end else if (fall) begin
					// drive read turnaround low, then the data bits
					if (st_q.fr == F_TA && st_q.cnt == TA_CNT_LAST && st_q.is_rd && st_q.match) begin
						st_d.sd_oe = 1'b1; // R22
						st_d.sd_o  = 1'b0;
					end else if (st_q.fr == F_DATA && st_q.is_rd && st_q.match) begin
						st_d.sd_o = st_q.sh[15]; // R23
						st_d.sh   = {st_q.sh[14:0], 1'b0};
					end else if (st_q.fr == F_REL) begin
						st_d.sd_oe = 1'b0;
						st_d.fr    = F_IDLE;
					end
				end
			end
		endcase
	end
	// state register with synchronous reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= RESET_STATE; // R22
		end else begin
			st_q <= st_d;
		end
	end
	// outputs straight from the state register
	assign rom_select_pin_o    = st_q.cs_o;
	assign rom_select_pin_oe   = st_q.pins_oe;
	assign serial_clock_pin_o  = st_q.sk_o;
	assign serial_clock_pin_oe = st_q.pins_oe;
	assign serial_data_pin_o   = st_q.sd_o;
	assign serial_data_pin_oe  = st_q.sd_oe;
	assign reg_wr_stb          = st_q.wr;
	assign reg_rd_stb          = st_q.rd;
	assign reg_addr            = st_q.ra;
	assign reg_wdata           = st_q.wd;
	assign flow_ctrl_en        = st_q.fc;
	assign mgmt_wide_mode      = st_q.wide;
	assign port5_mode          = st_q.p5;
	assign backpressure_en     = st_q.bp;
	assign autoneg_en          = st_q.an_en;
	assign crossover_en        = st_q.xo_en;
	assign led_dual_color      = st_q.led;
	assign load_busy           = st_q.busy;
	assign load_done           = st_q.done;
	assign signature_ok        = st_q.sig_ok;
	// checks on the design's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_strap_capture: assert property ((st_q.top == ST_CAPTURE) |=> // R01
		(st_q.wide == $past(wide_s) && st_q.led == $past(led_s) && st_q.bp == $past(bp_s)))
		else $error("straps not latched");
	a_flow_forced: assert property (st_q.gfc ##1 st_q.gfc |-> flow_ctrl_en == ALL_PORTS) // R02
		else $error("flow control not forced on");
	a_fiber_autoneg: assert property (##1 (autoneg_en & $past(port_is_fiber)) == 6'h00) // R06
		else $error("autoneg enabled on fiber port");
	a_port5_legal: assert property (st_q.top != ST_CAPTURE |-> port5_mode != P5_RESERVED) // R04
		else $error("reserved port 5 mode");
	a_skip_load: assert property ((st_q.top == ST_PROBE && !eo_s) |=> // R10
		(st_q.top == ST_SERVE && load_done && !rom_select_pin_oe))
		else $error("load not skipped");
	a_sig_gate: assert property ((reg_wr_stb && st_q.top != ST_SERVE && reg_addr == 10'h000) // R09
		|-> reg_wdata == SIGNATURE_WORD)
		else $error("load without signature");
	a_load_pins: assert property ((st_q.top == ST_LOAD) |-> // R22
		(rom_select_pin_oe && serial_clock_pin_oe && serial_data_pin_oe))
		else $error("load pins not driven");
	a_serve_pins: assert property ((st_q.top == ST_SERVE) |-> // R22
		(!rom_select_pin_oe && !serial_clock_pin_oe))
		else $error("select or clock driven while serving");
	a_rom_read_quiet: assert property ((st_q.fr inside {F_EST, F_EOP, F_EADDR, F_EDATA, F_EWAIT}) // R13
		|-> !serial_data_pin_oe)
		else $error("device answered rom read");
	a_foreign_quiet: assert property ((st_q.top == ST_SERVE && !st_q.match) |-> // R21
		!serial_data_pin_oe)
		else $error("data pin driven for foreign address");
	// address being completed falls inside our own space
	logic na_ok;
	assign na_ok = ({st_q.sh[8:0], sd_s} <= MGMT_ADDR_LAST);
	a_read_strobe: assert property ((st_q.fr == F_ADDR && rise && st_q.cnt == ADDR_CNT_LAST // R18
		&& st_q.is_rd && na_ok) |=> reg_rd_stb)
		else $error("read strobe missing");
	c_load_full: cover property (st_q.top == ST_LOAD ##1 st_q.top == ST_SERVE && signature_ok);
	c_load_skip: cover property (st_q.top == ST_PROBE ##1 st_q.top == ST_SERVE);
	c_mgmt_read: cover property (st_q.fr == F_REL && serial_data_pin_oe);
	c_rom_write: cover property (st_q.fr == F_EDATA ##1 reg_wr_stb);
endmodule : switch_config_access_port
`default_nettype wire

//--- rom_model.sv
// behavioural serial configuration eeprom that answers word reads
`timescale 1ns/1ps
`default_nettype none
module rom_model #(
	parameter logic [15:0] SIG = 16'h1d2e // arbitrary value
) (
	// serial pins as seen on the board
	input  wire logic cs,
	input  wire logic sk,
	input  wire logic di,
	// word 0 holds a wrong signature when set
	input  wire logic bad,
	// answer line
	output logic      dout
);
	int          n = 0;    // bits clocked since select
	logic [9:0]  sh;       // command bits taken so far
	logic [15:0] w;        // word being shifted out
	logic        q = 1'b1; // driven answer bit
	logic [7:0]  a;        // word address
	// a deselected part releases the line to the board pull-up
	assign dout = cs ? q : 1'b1;
	// take start, opcode and address, then a dummy 0 and the word msb first
	always @(posedge sk or negedge cs) begin
		if (!cs) begin
			n = 0;
		end else begin
			if (n == 10) begin
				a = {sh[6:0], di};
				w = (a == 8'h00) ? (bad ? ~SIG : SIG) : {a, ~a};
				q = 1'b0;
			end else if (n > 10 && n < 27) begin
				q = w[15];
				w = {w[14:0], 1'b0};
			end
			sh = {sh[8:0], di};
			n = n + 1;
		end
	end
endmodule : rom_model
`default_nettype wire

//--- test_switch_config_access_port.sv
// self-checking bench for the configuration access port with eeprom and host
`timescale 1ns/1ps
`default_nettype none
module test_switch_config_access_port;
	import cfg_access_pkg::*;
	localparam logic [15:0] SIG = 16'h1d2e; // arbitrary value
	// clock, reset and board levels
	logic        sys_clk = 1'b0;
	logic        rst     = 1'b1;
	logic [5:0]  straps, fib, flow;
	logic [1:0]  p5;
	logic        rom_skip, rom_bad, rom_q;
	// host side of the shared pins
	logic        host_oe, host_cs, host_sk, host_d, host_d_oe, quiet;
	wire         cs_w, sk_w, di_w, do_w;
	// design outputs
	logic        cs_o, cs_oe, sk_o, sk_oe, dq_o, dq_oe, wr, rd, wide, bp_en, led2;
	logic        busy, done, sig_ok;
	logic [9:0]  addr;
	logic [15:0] wdata, rdata;
	logic [5:0]  flow_en, an_en, xo_en;
	logic [1:0]  p5_mode;
	// expected strobes and counters
	logic [27:0] exp_q[$];
	int          fails      = 0;
	int          n_compared = 0;
	// wire levels: design first, then host, else pull-down or pull-up
	assign cs_w  = cs_oe ? cs_o : (host_oe ? host_cs : 1'b0);
	assign sk_w  = sk_oe ? sk_o : (host_oe ? host_sk : 1'b0);
	assign di_w  = dq_oe ? dq_o : (host_d_oe ? host_d : 1'b1);
	assign do_w  = rom_skip ? 1'b0 : rom_q;
	assign rdata = {addr[5:0], ~addr};
	always #50 sys_clk = ~sys_clk;
	switch_config_access_port #(.SIGNATURE_WORD(SIG)) dut_u (
		.sys_clk(sys_clk), .rst(rst),
		.global_flow_ctrl_strap(straps[5]), .mgmt_width_strap(straps[4]),
		.port5_bus_strap(p5), .backpressure_strap(straps[3]), .autoneg_strap(straps[2]),
		.crossover_strap(straps[1]), .led_style_strap(straps[0]),
		.port_is_fiber(fib), .port_flow_cfg(flow),
		.rom_select_pin_i(cs_w), .rom_select_pin_o(cs_o), .rom_select_pin_oe(cs_oe),
		.serial_clock_pin_i(sk_w), .serial_clock_pin_o(sk_o), .serial_clock_pin_oe(sk_oe),
		.serial_data_pin_i(di_w), .serial_data_pin_o(dq_o), .serial_data_pin_oe(dq_oe),
		.rom_data_out_pin_i(do_w), .reg_wr_stb(wr), .reg_rd_stb(rd), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .flow_ctrl_en(flow_en), .mgmt_wide_mode(wide),
		.port5_mode(p5_mode), .backpressure_en(bp_en), .autoneg_en(an_en),
		.crossover_en(xo_en), .led_dual_color(led2), .load_busy(busy), .load_done(done),
		.signature_ok(sig_ok));
	rom_model #(.SIG(SIG)) rom_u (.cs(cs_w), .sk(sk_w), .di(di_w), .bad(rom_bad), .dout(rom_q));
	// wait n edges, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask : tick
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		n_compared++;
		if (seen !== want) begin
			fails++;
			$display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask : check
	// one host clock of 800 ns, data sampled mid high phase
	task automatic bit_io(input logic b, input logic drv, output logic s);
		host_sk   = 1'b0;
		host_d    = b;
		host_d_oe = drv;
		tick(4);
		host_sk = 1'b1;
		tick(2);
		s = di_w;
		tick(2);
	endtask : bit_io
	// drive n bits msb first
	task automatic send(input logic [63:0] v, input int n);
		logic s;
		for (int i = n - 1; i >= 0; i--) bit_io(v[i], 1'b1, s);
	endtask : send
	// management frame; ok clear means the device must stay silent
	task automatic mgmt(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d,
		input logic ok);
		logic        s;
		logic [15:0] r;
		quiet = !ok;
		if (ok)
			exp_q.push_back({op == MGMT_OP_WRITE, op == MGMT_OP_READ, a, op[0] ? d : 16'h0});
		if (op == MGMT_OP_WRITE) begin
			send(64'({2'b01, op, a, 2'b10, d}), 32);
		end else begin
			send(64'({2'b01, op, a}), 14);
			bit_io(1'b1, 1'b0, s);
			bit_io(1'b1, 1'b0, s);
			check(32'(s), ok ? 32'h0 : 32'h1, "turnaround");
			for (int i = 15; i >= 0; i--) bit_io(1'b1, 1'b0, r[i]);
			check(32'(r), ok ? 32'({a[5:0], ~a}) : 32'hffff, "read data");
		end
		send(64'h1, 1);
		quiet = 1'b0;
	endtask : mgmt
	// eeprom-format command with select high, then one spare clock
	task automatic rom_cmd(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d);
		quiet = (op != EE_OP_WRITE);
		if (!quiet) exp_q.push_back({4'h8, a, d});
		host_cs = 1'b1;
		send(64'({1'b1, op, a, d}), 27);
		host_cs = 1'b0;
		send(64'h1, 1);
		quiet = 1'b0;
	endtask : rom_cmd
	// reset with random straps, check latching, wait for the load to end
	task automatic do_reset(input logic [1:0] code, input logic skip, input logic bad);
		logic [31:0] want;
		rst       = 1'b1;
		host_oe   = 1'b0;
		host_d_oe = 1'b0;
		straps    = 6'($urandom);
		fib       = 6'($urandom);
		flow      = 6'($urandom);
		p5        = code;
		rom_skip  = skip;
		rom_bad   = bad;
		tick(3);
		rst = 1'b0;
		if (!skip && !bad)
			for (int w = 0; w <= 'h9c; w++)
				exp_q.push_back({4'h8, 8'(w), w == 0 ? SIG : {8'(w), ~8'(w)}});
		tick(3);
		want = 32'({straps[5] ? 6'h3f : flow, straps[4], p5 == 2'h3 ? 2'h0 : p5, straps[3],
			straps[2] ? ~fib : 6'h0, straps[1] ? ~fib : 6'h0, straps[0]});
		check(32'({flow_en, wide, p5_mode, bp_en, an_en, xo_en, led2}), want, "straps");
		check(32'({cs_oe, sk_oe, dq_oe, busy}), skip ? 32'h0 : 32'hf, "load pins");
		straps = ~straps;
		p5     = ~p5;
		tick(4);
		check(32'({flow_en, wide, p5_mode, bp_en, an_en, xo_en, led2}), want, "latch");
		for (int i = 0; i < 40000 && done !== 1'b1; i++) tick(1);
		tick(4);
		want = 32'({2'b10, !skip && !bad, 3'b000});
		check(32'({done, busy, sig_ok, cs_oe, sk_oe, dq_oe}), want, "end");
		check(32'(exp_q.size()), 32'h0, "words left");
		host_oe = 1'b1;
		host_cs = 1'b0;
		host_sk = 1'b0;
	endtask : do_reset
	// verdict
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	// watch strobes against the notes and the data pin while it must float
	always @(posedge sys_clk) begin
		if (quiet) check(32'(dq_oe), 32'h0, "pin driven");
		if (!rst && (wr | rd) !== 1'b0) begin
			if (exp_q.size() == 0) check(32'h1, 32'h0, "extra strobe");
			else check(32'({wr, rd, addr, rd ? 16'h0 : wdata}), 32'(exp_q.pop_front()), "strobe");
		end
	end
	// hang guard
	initial begin
		repeat (60000) @(posedge sys_clk);
		fails++;
		$display("MISMATCH t=%0t watchdog", $time);
		results();
	end
	// main sequence: load cases around one write sent without preamble, then host traffic
	initial begin
		{straps, fib, flow, p5, rom_skip, rom_bad} = '0;
		{host_oe, host_cs, host_sk, host_d_oe, quiet} = '0;
		host_d = 1'b1;
		void'($urandom(68774));
		do_reset(2'h0, 1'b0, 1'b0);
		do_reset(2'h1, 1'b0, 1'b1);
		do_reset(2'h3, 1'b1, 1'b0);
		mgmt(MGMT_OP_WRITE, 10'h040, 16'h1234, 1'b0);
		do_reset(2'h2, 1'b1, 1'b0);
		send(64'hffff_ffff, 32);
		mgmt(MGMT_OP_WRITE, 10'h2ff, 16'($urandom), 1'b1);
		mgmt(MGMT_OP_WRITE, 10'($urandom_range(0, 'h2ff)), 16'($urandom), 1'b1);
		mgmt(MGMT_OP_READ, 10'h180, 16'h0, 1'b1);
		mgmt(MGMT_OP_READ, 10'h300, 16'h0, 1'b0);
		mgmt(MGMT_OP_WRITE, 10'h3ff, 16'h5555, 1'b0);
		quiet = 1'b1;
		send(64'h40f, 12);
		send(64'h7ff, 12);
		quiet = 1'b0;
		mgmt(MGMT_OP_READ, 10'($urandom_range(0, 'h2ff)), 16'h0, 1'b1);
		rom_cmd(EE_OP_WRITE, 8'($urandom), 16'($urandom));
		rom_cmd(EE_OP_READ, 8'h02, 16'h0);
		rom_cmd(EE_OP_WRITE, 8'h9c, 16'h2222);
		tick(4);
		check(32'(exp_q.size()), 32'h0, "strobes left");
		results();
	end
endmodule : test_switch_config_access_port
`default_nettype wire
